/* File: hw/bias_seq_pkg.sv */
// Constants, offsets and types shared by the bias supply sequencer files.
// Assumes a single 250 MHz clock domain.
package bias_seq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ          = 250;
	localparam int SS_TIME_US       = 14000;
	localparam int FAULT_TIME_MS    = 120;
	localparam int OSC_FREQ_KHZ     = 1200;
	localparam int SS_CYCLES_DEF    = SS_TIME_US * CLK_MHZ;
	localparam int FAULT_CYCLES_DEF = FAULT_TIME_MS * 1000 * CLK_MHZ;
	// Rounded down: the oscillator period never exceeds nominal
	localparam int OSC_CYCLES       = (CLK_MHZ * 1000) / OSC_FREQ_KHZ;
	localparam int RAMP_STEPS       = 256;
	localparam int ILIM_STEPS       = 8;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam int         CTRL_ENABLE_BIT = 0;
	localparam logic       CTRL_ENABLE_RST = 1'b1;
	localparam int         ST_STATE_LSB    = 0;
	localparam int         ST_FAULT_BIT    = 3;
	localparam int         ST_SSDONE_BIT   = 4;
	localparam int         ST_ACTIVE_BIT   = 5;
	localparam int         ST_ILIM_LSB     = 6;
	localparam int         ST_UV_BIT       = 9;
	localparam int         ST_REFSEL_BIT   = 10;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_REF_WAIT = 3'b001,
		ST_SOFT     = 3'b010,
		ST_DELAY    = 3'b011,
		ST_ACTIVE   = 3'b100,
		ST_FAULT    = 3'b101
	} seq_state_t;

endpackage

/* File: hw/seq_if.sv */
// Carrier between the sequencer core and its switch latch and fault timer.
// Assumes all three ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface seq_if;
	logic pwm_run;
	logic peak_trip;
	logic limit_trip;
	logic pwm_gate;
	logic ft_run;
	logic ft_uv;
	logic ft_expired;
	modport core (output pwm_run, output peak_trip, output limit_trip, input pwm_gate,
		output ft_run, output ft_uv, input ft_expired);
	modport pwm (input pwm_run, input peak_trip, input limit_trip, output pwm_gate);
	modport ftimer (input ft_run, input ft_uv, output ft_expired);
endinterface
`default_nettype wire

/* File: hw/boost_switch_latch.sv */
// Set-reset latch driving the boost power switch at the oscillator rate.
// Assumes comparator flags are synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module boost_switch_latch import bias_seq_pkg::*; (
	input  wire logic aclk,
	input  wire logic aresetn,
	seq_if.pwm        sif
);
	localparam int CNT_W = $clog2(OSC_CYCLES);

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             gate;
	} latch_t;

	latch_t s;
	latch_t n;

	// ****************************************
	// Latch
	// ****************************************
	always_comb begin
		n = s;
		if (s.cnt == CNT_W'(OSC_CYCLES - 1)) begin
			n.cnt = '0;
		end else begin
			n.cnt = s.cnt + 1'b1;
		end
		// Trip beats cycle start so the peak stays capped
		if (!sif.pwm_run || sif.peak_trip || sif.limit_trip) begin
			n.gate = 1'b0;
		end else if (s.cnt == '0) begin
			n.gate = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign sif.pwm_gate = s.gate;
endmodule
`default_nettype wire

/* File: hw/fault_timer.sv */
// Undervoltage fault timer; restarts whenever every output recovers.
// Assumes ft_run and ft_uv are registered or synchronous inputs.
`timescale 1ns/1ns
`default_nettype none
module fault_timer import bias_seq_pkg::*; #(
	parameter int LIMIT = FAULT_CYCLES_DEF
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	seq_if.ftimer     sif
);
	localparam int CNT_W = $clog2(LIMIT + 1);

	if (LIMIT < 2) begin : g_chk
		$error("fault_timer: LIMIT too small");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             expired;
	} timer_t;

	timer_t s;
	timer_t n;

	// ****************************************
	// Counter
	// ****************************************
	always_comb begin
		n = s;
		if (sif.ft_run && sif.ft_uv) begin
			if (s.cnt != CNT_W'(LIMIT)) begin
				n.cnt = s.cnt + 1'b1;
			end
		end else begin
			n.cnt = '0;
		end
		n.expired = (n.cnt == CNT_W'(LIMIT));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign sif.ft_expired = s.expired;
endmodule
`default_nettype wire

/* File: hw/lcd_bias_startup_fault_sequencer.sv */
// Startup, soft-start, switch delay and fault sequencing of a display bias supply,
// with an AXI4-Lite register slave.
// Assumes all comparator flags are synchronous to aclk and clean of glitches.
`timescale 1ns/1ns
`default_nettype none
// Function
// - Start on supply above rising threshold; stop below falling threshold.
// - Reference above enable level turns on boost and both gate rails together.
// - Boost current limit climbs in eight steps during soft-start.
// - One soft-start interval for all regulators; full load only after it.
// - Gate rails follow a ramp until it reaches reference, then reference.
// - Delay capacitor charging starts after soft-start with no fault present.
// - Delay comparator crossing enables the switch control block.
// - Delay node shorted to ground before startup and in lockout.
// - Select input ignored until supply, soft-start, no fault, delay all hold.
// - High select closes source switch; low select closes drain switch.
// - Fault timer runs while any output is below its threshold.
// - Fault timer expiry sets a latch shutting all outputs but reference.
// - Gate-on rail undervoltage flagged below reference by fixed offset.
// - Gate-off rail undervoltage flagged above its reference by fixed offset.
// - Over-temperature shuts the device down.
// - Oscillator sets power switch latch; peak comparator resets it.
// - Boost switch peak current capped at active limit level.
module lcd_bias_startup_fault_sequencer import bias_seq_pkg::*; #(
	parameter int ADDR_W       = 8,
	parameter int SS_CYCLES    = SS_CYCLES_DEF,
	parameter int FAULT_CYCLES = FAULT_CYCLES_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Comparator flags
	input  wire logic              supply_above_rise,
	input  wire logic              supply_below_fall,
	input  wire logic              ref_above_enable,
	input  wire logic              main_feedback_low,
	input  wire logic              gate_on_rail_low,
	input  wire logic              gate_off_rail_high,
	input  wire logic              over_temp,
	input  wire logic              startup_timing_node_high,
	input  wire logic              switch_select_input,
	input  wire logic              peak_current_comparator,
	input  wire logic              current_limit_comparator,
	// Enables and switch gates
	output logic                   boost_enable,
	output logic                   gate_on_rail_enable,
	output logic                   gate_off_rail_enable,
	output logic [2:0]             current_limit_level,
	output logic                   full_load_ok,
	output logic [7:0]             rail_ramp_code,
	output logic                   rail_ref_select,
	output logic                   timing_charge_enable,
	output logic                   timing_discharge,
	output logic                   switch_control_active,
	output logic                   source_side_switch,
	output logic                   drain_side_switch,
	output logic                   power_switch_gate
);
	localparam int STEP_CYCLES = SS_CYCLES / RAMP_STEPS;
	localparam int STEP_W      = $clog2(STEP_CYCLES + 1);

	if (ADDR_W < 3 || ADDR_W > 32 || SS_CYCLES < 2 * RAMP_STEPS) begin : g_chk
		$error("sequencer: unsupported ADDR_W or SS_CYCLES");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		seq_state_t        state;
		logic              fault_latch;
		logic              enable;
		logic [STEP_W-1:0] step_cnt;
		logic [7:0]        ramp;
		logic              ss_done;
		logic              boost_en;
		logic              gon_en;
		logic              goff_en;
		logic              full_load;
		logic              ref_sel;
		logic              charge;
		logic              discharge;
		logic              active;
		logic              src_sw;
		logic              drn_sw;
		logic              awready;
		logic              wready;
		logic              aw_got;
		logic              w_got;
		logic              bvalid;
		logic [1:0]        bresp;
		logic [ADDR_W-1:0] waddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
	} state_t;

	state_t      s;
	state_t      n;
	logic        any_uv;
	logic        sw_gate;
	logic [31:0] status_word;
	seq_if       sif ();

	// Drops the sequence but keeps the fault latch, enable and bus state
	function automatic state_t go_idle(input state_t cur);
		state_t r;
		r           = cur;
		r.state     = ST_IDLE;
		r.step_cnt  = '0;
		r.ramp      = '0;
		r.ss_done   = 1'b0;
		r.boost_en  = 1'b0;
		r.gon_en    = 1'b0;
		r.goff_en   = 1'b0;
		r.full_load = 1'b0;
		r.ref_sel   = 1'b0;
		r.charge    = 1'b0;
		r.discharge = 1'b1;
		r.active    = 1'b0;
		r.src_sw    = 1'b0;
		r.drn_sw    = 1'b0;
		return r;
	endfunction

	// Rail comparators carry their own offsets; here they only merge
	assign any_uv = main_feedback_low | gate_on_rail_low | gate_off_rail_high;

	always_comb begin
		status_word                                  = '0;
		status_word[ST_STATE_LSB +: 3]               = s.state;
		status_word[ST_FAULT_BIT]                    = s.fault_latch;
		status_word[ST_SSDONE_BIT]                   = s.ss_done;
		status_word[ST_ACTIVE_BIT]                   = s.active;
		status_word[ST_ILIM_LSB +: 3]                = s.ramp[7:5];
		status_word[ST_UV_BIT]                       = any_uv;
		status_word[ST_REFSEL_BIT]                   = s.ref_sel;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		n = s;

		// Register bus: address and data taken in either order
		if (s.awready && awvalid) begin
			n.awready = 1'b0;
			n.aw_got  = 1'b1;
			n.waddr   = awaddr;
		end
		if (s.wready && wvalid) begin
			n.wready = 1'b0;
			n.w_got  = 1'b1;
			n.wdata  = wdata;
			n.wstrb  = wstrb;
		end
		if (s.aw_got && s.w_got) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			if ({s.waddr[ADDR_W-1:2], 2'b00} == ADDR_W'(CTRL_OFFSET)) begin
				if (s.wstrb[0]) begin
					n.enable = s.wdata[CTRL_ENABLE_BIT];
				end
				n.bresp = RESP_OKAY;
			end else if ({s.waddr[ADDR_W-1:2], 2'b00} == ADDR_W'(STATUS_OFFSET)) begin
				n.bresp = RESP_OKAY;
			end else begin
				n.bresp = RESP_SLVERR;
			end
		end
		if (s.bvalid && bready) begin
			n.bvalid  = 1'b0;
			n.awready = 1'b1;
			n.wready  = 1'b1;
		end
		if (s.arready && arvalid) begin
			n.arready = 1'b0;
			n.rvalid  = 1'b1;
			n.rresp   = RESP_OKAY;
			if ({araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(CTRL_OFFSET)) begin
				n.rdata = {31'h0000_0000, s.enable};
			end else if ({araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(STATUS_OFFSET)) begin
				n.rdata = status_word;
			end else begin
				n.rdata = 32'h0000_0000;
				n.rresp = RESP_SLVERR;
			end
		end
		if (s.rvalid && rready) begin
			n.rvalid  = 1'b0;
			n.arready = 1'b1;
		end

		// Sequencer
		case (s.state)
			ST_IDLE: begin
				if (supply_above_rise && !over_temp && s.enable && !s.fault_latch) begin
					n.state = ST_REF_WAIT;
				end
			end
			ST_REF_WAIT: begin
				if (ref_above_enable) begin
					n.state    = ST_SOFT;
					n.boost_en = 1'b1;
					n.gon_en   = 1'b1;
					n.goff_en  = 1'b1;
				end
			end
			ST_SOFT: begin
				// One step counter paces both the rail ramp and the limit staircase
				if (!s.ss_done) begin
					if (s.step_cnt == STEP_W'(STEP_CYCLES - 1)) begin
						n.step_cnt = '0;
						if (s.ramp != 8'hFF) begin
							n.ramp = s.ramp + 8'h01;
						end else begin
							n.ss_done = 1'b1;
						end
					end else begin
						n.step_cnt = s.step_cnt + 1'b1;
					end
				end
				if (n.ramp == 8'hFF) begin
					n.ref_sel = 1'b1;
				end
				if (s.ss_done) begin
					n.full_load = 1'b1;
					if (!any_uv) begin
						n.state     = ST_DELAY;
						n.charge    = 1'b1;
						n.discharge = 1'b0;
					end
				end
			end
			ST_DELAY: begin
				if (startup_timing_node_high) begin
					n.state  = ST_ACTIVE;
					n.active = 1'b1;
				end
			end
			ST_ACTIVE: begin
			end
			ST_FAULT: begin
			end
			default: begin
				n.state = ST_IDLE;
			end
		endcase

		// Fault latch: only the reference survives
		if (sif.ft_expired && s.boost_en) begin
			n             = go_idle(n);
			n.fault_latch = 1'b1;
			n.state       = ST_FAULT;
		end

		// Lockout, heat or software disable win over everything else
		if (supply_below_fall || over_temp || !s.enable) begin
			n = go_idle(n);
			if (supply_below_fall) begin
				n.fault_latch = 1'b0;
			end
		end

		// Switch control
		sw_gate  = n.active && !supply_below_fall && n.ss_done && !n.fault_latch
			&& startup_timing_node_high;
		n.src_sw = sw_gate && switch_select_input;
		n.drn_sw = sw_gate && !switch_select_input;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s           <= '0;
			s.enable    <= CTRL_ENABLE_RST;
			s.discharge <= 1'b1;
			s.awready   <= 1'b1;
			s.wready    <= 1'b1;
			s.arready   <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// ****************************************
	// Power switch latch and fault timer
	// ****************************************
	assign sif.pwm_run    = s.boost_en;
	assign sif.peak_trip  = peak_current_comparator;
	assign sif.limit_trip = current_limit_comparator;
	assign sif.ft_run     = s.boost_en;
	assign sif.ft_uv      = any_uv;

	boost_switch_latch u_latch (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sif     (sif.pwm)
	);

	fault_timer #(
		.LIMIT (FAULT_CYCLES)
	) u_ftimer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sif     (sif.ftimer)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign awready               = s.awready;
	assign wready                = s.wready;
	assign bvalid                = s.bvalid;
	assign bresp                 = s.bresp;
	assign arready               = s.arready;
	assign rvalid                = s.rvalid;
	assign rresp                 = s.rresp;
	assign rdata                 = s.rdata;
	assign boost_enable          = s.boost_en;
	assign gate_on_rail_enable   = s.gon_en;
	assign gate_off_rail_enable  = s.goff_en;
	assign current_limit_level   = s.ramp[7:5];
	assign full_load_ok          = s.full_load;
	assign rail_ramp_code        = s.ramp;
	assign rail_ref_select       = s.ref_sel;
	assign timing_charge_enable  = s.charge;
	assign timing_discharge      = s.discharge;
	assign switch_control_active = s.active;
	assign source_side_switch    = s.src_sw;
	assign drain_side_switch     = s.drn_sw;
	assign power_switch_gate     = sif.pwm_gate;
endmodule
`default_nettype wire

/* File: tb/bias_seq_monitor.sv */
// Concurrent checks on the bias sequencer top-level ports.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ns
`default_nettype none
module bias_seq_monitor (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       supply_below_fall,
	input wire logic       over_temp,
	input wire logic       switch_select_input,
	input wire logic       startup_timing_node_high,
	input wire logic       peak_current_comparator,
	input wire logic       current_limit_comparator,
	input wire logic       boost_enable,
	input wire logic       gate_on_rail_enable,
	input wire logic       gate_off_rail_enable,
	input wire logic [2:0] current_limit_level,
	input wire logic       full_load_ok,
	input wire logic       rail_ref_select,
	input wire logic       timing_charge_enable,
	input wire logic       timing_discharge,
	input wire logic       switch_control_active,
	input wire logic       source_side_switch,
	input wire logic       drain_side_switch,
	input wire logic       power_switch_gate
);
	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_trip;
		power_switch_gate && (peak_current_comparator || current_limit_comparator);
	endsequence
	sequence s_off;
		!power_switch_gate;
	endsequence
	AST_RAILS_TOGETHER: assert property (boost_enable == gate_on_rail_enable && boost_enable == gate_off_rail_enable)
		else $error("regulator enables differ");
	AST_LOCKOUT_IDLE: assert property (supply_below_fall |=> !boost_enable && timing_discharge && !switch_control_active)
		else $error("lockout did not idle the sequencer");
	AST_THERMAL_OFF: assert property (over_temp |=> !boost_enable && !source_side_switch && !drain_side_switch)
		else $error("over-temperature did not shut down");
	AST_STAIRCASE: assert property ($changed(current_limit_level) |-> current_limit_level == $past(current_limit_level) + 3'h1 || current_limit_level == 3'h0)
		else $error("current limit skipped a step");
	AST_FULL_LOAD: assert property (full_load_ok |-> rail_ref_select && current_limit_level == 3'h7)
		else $error("full load before soft-start end");
	AST_CHARGE_GATE: assert property (timing_charge_enable |-> rail_ref_select && boost_enable && !timing_discharge)
		else $error("delay charge too early");
	AST_SOURCE_GATE: assert property (source_side_switch |-> $past(switch_select_input) && $past(startup_timing_node_high) && !$past(supply_below_fall))
		else $error("source switch closed without cause");
	AST_DRAIN_GATE: assert property (drain_side_switch |-> !$past(switch_select_input) && $past(startup_timing_node_high) && !source_side_switch)
		else $error("drain switch closed without cause");
	AST_PWM_TRIP: assert property (s_trip |-> ##[1:2] s_off)
		else $error("power switch not released after trip");
endmodule
bind lcd_bias_startup_fault_sequencer bias_seq_monitor mon_u (.aclk, .aresetn, .supply_below_fall, .over_temp,
	.switch_select_input, .startup_timing_node_high, .peak_current_comparator, .current_limit_comparator,
	.boost_enable, .gate_on_rail_enable, .gate_off_rail_enable, .current_limit_level, .full_load_ok,
	.rail_ref_select, .timing_charge_enable, .timing_discharge, .switch_control_active,
	.source_side_switch, .drain_side_switch, .power_switch_gate);
`default_nettype wire

/* File: tb/bias_analog_model.sv */
// Behavioural model of reference, delay capacitor and inductor current.
// Assumes the sequencer and this model share aclk.
`timescale 1ns/1ns
`default_nettype none
module bias_analog_model #(
	parameter int REF_CYC  = 8,
	parameter int DEL_CYC  = 20,
	parameter int PEAK_CYC = 50
) (
	input  wire logic aclk,
	input  wire logic supply_above_rise,
	input  wire logic timing_charge_enable,
	input  wire logic timing_discharge,
	input  wire logic power_switch_gate,
	output logic      ref_above_enable,
	output logic      startup_timing_node_high,
	output logic      peak_current_comparator
);
	int ref_cnt;
	int del_cnt;
	int on_cnt;
	// Reference only charges while supply is up
	always @(posedge aclk) begin
		ref_cnt <= supply_above_rise ? ref_cnt + 1 : 0;
		del_cnt <= timing_discharge ? 0 : (timing_charge_enable ? del_cnt + 1 : del_cnt);
		on_cnt  <= power_switch_gate ? on_cnt + 1 : 0;
	end
	assign ref_above_enable         = ref_cnt >= REF_CYC;
	assign startup_timing_node_high = del_cnt >= DEL_CYC;
	assign peak_current_comparator  = on_cnt >= PEAK_CYC;
endmodule
`default_nettype wire

/* File: tb/test_lcd_bias_startup_fault_sequencer.sv */
// Self-checking bench for the bias sequencer.
// Assumes shortened soft-start and fault timers.
`timescale 1ns/1ns
`default_nettype none
module test_lcd_bias_startup_fault_sequencer;
	import bias_seq_pkg::*;
	localparam int SS = 512;
	localparam int FC = 100;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, q;
	logic [3:0] wstrb;
	logic [1:0] r;
	logic supply_above_rise, supply_below_fall, main_feedback_low, gate_on_rail_low, gate_off_rail_high;
	logic over_temp, switch_select_input, current_limit_comparator;
	wire logic awready, wready, bvalid, arready, rvalid, ref_above_enable, startup_timing_node_high;
	wire logic peak_current_comparator, boost_enable, gate_on_rail_enable, gate_off_rail_enable, full_load_ok;
	wire logic rail_ref_select, timing_charge_enable, timing_discharge, switch_control_active;
	wire logic source_side_switch, drain_side_switch, power_switch_gate;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] current_limit_level;
	wire logic [7:0] rail_ramp_code;
	int fail_count, compares;
	lcd_bias_startup_fault_sequencer #(.SS_CYCLES(SS), .FAULT_CYCLES(FC)) dut_u (.aclk, .aresetn, .awaddr,
		.awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .supply_above_rise, .supply_below_fall, .ref_above_enable,
		.main_feedback_low, .gate_on_rail_low, .gate_off_rail_high, .over_temp, .startup_timing_node_high,
		.switch_select_input, .peak_current_comparator, .current_limit_comparator, .boost_enable,
		.gate_on_rail_enable, .gate_off_rail_enable, .current_limit_level, .full_load_ok, .rail_ramp_code,
		.rail_ref_select, .timing_charge_enable, .timing_discharge, .switch_control_active,
		.source_side_switch, .drain_side_switch, .power_switch_gate);
	bias_analog_model model_u (.aclk, .supply_above_rise, .timing_charge_enable, .timing_discharge,
		.power_switch_gate, .ref_above_enable, .startup_timing_node_high, .peak_current_comparator);
	// ****************************************
	// Helpers
	// ****************************************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task end_sim;
		$display("Comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Single bus cycle; holds each channel until its own handshake
	task axi(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		if (we) begin
			awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		end else begin
			araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		end
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (arvalid && arready) arvalid <= 1'b0;
			if (we ? bvalid : rvalid) break;
		end
		r = we ? bresp : rresp;
		q = rdata;
		bready <= 1'b0;
		rready <= 1'b0;
		if (n == 100) begin
			chk("bus answer", 0, 1);
			end_sim;
		end
	endtask
	task wait_for(input int which, input int lim);
		int n;
		bit hit;
		hit = 0;
		for (n = 0; n < lim && !hit; n++) begin
			@(posedge aclk);
			case (which)
				0: hit = boost_enable === 1'b1;
				1: hit = full_load_ok === 1'b1;
				2: hit = switch_control_active === 1'b1;
				default: hit = boost_enable === 1'b0;
			endcase
		end
		if (!hit) begin
			chk("wait", which, 99);
			end_sim;
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		@(posedge aclk);
		chk("timing_discharge", timing_discharge, 1);
		chk("awready", awready, 1);
		axi(0, CTRL_OFFSET, 0); chk("ctrl", q, 1);
		axi(1, CTRL_OFFSET, 0); chk("bresp", r, RESP_OKAY);
		axi(0, CTRL_OFFSET, 0); chk("ctrl", q, 0);
		axi(1, CTRL_OFFSET, 1);
		wstrb <= 4'hE;
		axi(1, CTRL_OFFSET, 0);
		wstrb <= 4'hF;
		axi(0, CTRL_OFFSET, 0); chk("ctrl lane 0 off", q, 1);
		axi(1, 8'h40, 0); chk("bresp unmapped", r, RESP_SLVERR);
		axi(1, STATUS_OFFSET, 32'hFFFFFFFF); chk("bresp", r, RESP_OKAY);
		axi(0, STATUS_OFFSET, 0); chk("state", q[2:0], 0);
		axi(0, 8'h40, 0); chk("rresp", r, RESP_SLVERR); chk("rdata", q, 0);
	endtask
	task t_start;
		int n;
		switch_select_input <= 1'b1;
		supply_above_rise <= 1'b1;
		wait_for(0, 200);
		chk("gate_on_rail_enable", gate_on_rail_enable, 1);
		chk("gate_off_rail_enable", gate_off_rail_enable, 1);
		chk("source ignored", source_side_switch, 0);
		wait_for(1, SS + 50);
		chk("rail_ramp_code", rail_ramp_code, 8'hFF);
		chk("timing_charge_enable", timing_charge_enable, 1);
		chk("current_limit_level", current_limit_level, 7);
		chk("rail_ref_select", rail_ref_select, 1);
		chk("source before delay", source_side_switch, 0);
		wait_for(2, 200);
		repeat (2) @(posedge aclk);
		chk("source", source_side_switch, 1);
		chk("drain", drain_side_switch, 0);
		switch_select_input <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("source", source_side_switch, 0);
		chk("drain", drain_side_switch, 1);
		for (n = 0; n < 300 && power_switch_gate !== 1'b1; n++) @(posedge aclk);
		chk("power_switch_gate on", power_switch_gate, 1);
		current_limit_comparator <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("power_switch_gate", power_switch_gate, 0);
		current_limit_comparator <= 1'b0;
	endtask
	// Two pulses, one clear cycle apart: together they pass the limit unless the timer restarts
	task t_fault_short;
		gate_off_rail_high <= 1'b1;
		axi(0, STATUS_OFFSET, 0); chk("gate-off uv", q[ST_UV_BIT], 1);
		repeat (FC - 30) @(posedge aclk);
		gate_off_rail_high <= 1'b0;
		@(posedge aclk);
		gate_on_rail_low <= 1'b1;
		axi(0, STATUS_OFFSET, 0); chk("gate-on uv", q[ST_UV_BIT], 1);
		repeat (FC - 30) @(posedge aclk);
		gate_on_rail_low <= 1'b0;
		repeat (FC) @(posedge aclk);
		chk("boost after recovery", boost_enable, 1);
	endtask
	task t_thermal;
		over_temp <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("boost hot", boost_enable, 0);
		axi(0, STATUS_OFFSET, 0); chk("state hot", q[2:0], 0);
		over_temp <= 1'b0;
		wait_for(0, 200);
	endtask
	task t_fault_latch;
		main_feedback_low <= 1'b1;
		wait_for(3, FC + 20);
		main_feedback_low <= 1'b0;
		chk("gate_on_rail_enable", gate_on_rail_enable, 0);
		axi(1, CTRL_OFFSET, 0);
		axi(1, CTRL_OFFSET, 1);
		repeat (20) @(posedge aclk);
		axi(0, STATUS_OFFSET, 0); chk("fault latch", q[3], 1);
		chk("boost latched", boost_enable, 0);
		supply_below_fall <= 1'b1;
		supply_above_rise <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("discharge lockout", timing_discharge, 1);
		supply_below_fall <= 1'b0;
		supply_above_rise <= 1'b1;
		wait_for(0, 200);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		{supply_above_rise, supply_below_fall, main_feedback_low, gate_on_rail_low} = '0;
		{gate_off_rail_high, over_temp, switch_select_input, current_limit_comparator} = '0;
		wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs;
		t_start;
		t_fault_short;
		t_thermal;
		t_fault_latch;
		end_sim;
	end
endmodule
`default_nettype wire
